// *** pkg/usm_pkg.sv ***
`default_nettype none
package usm_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] USM_OFF_DATA   = 8'h00; // shift_data_buffer
  localparam logic [7:0] USM_OFF_STATUS = 8'h04; // serial_flag_status
  localparam logic [7:0] USM_OFF_ENABLE = 8'h08; // serial_enable_control
  localparam logic [7:0] USM_OFF_FORMAT = 8'h0C; // serial_format_control
  localparam logic [7:0] USM_OFF_BAUD   = 8'h10; // baud_divider

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int USM_B_RXC    = 7; // receive_complete_flag
  localparam int USM_B_TXC    = 6; // transmit_complete_flag
  localparam int USM_B_UDRE   = 5; // tx_buffer_empty_flag
  localparam int USM_B_RXCIE  = 7; // rx_done_irq_enable
  localparam int USM_B_TXCIE  = 6; // tx_done_irq_enable
  localparam int USM_B_BUFFER_EMPTY_IRQ_ENABLE  = 5; // buffer_empty_irq_enable
  localparam int USM_B_RXEN   = 4; // receiver_enable
  localparam int USM_B_TXEN   = 3; // transmitter_enable
  localparam int USM_B_MODEHI = 7; // operating_mode_select, upper bit
  localparam int USM_B_MODELO = 6; // operating_mode_select, lower bit
  localparam int USM_B_ORDER  = 2; // bit_order_select
  localparam int USM_B_CPHA   = 1; // clock_phase_select
  localparam int USM_B_CPOL   = 0; // clock_polarity_select

  // ----------------------------------------------------------------------
  // Values after reset, encodings, counts
  // ----------------------------------------------------------------------
  localparam logic [7:0] USM_RST_ENABLE = 8'h00;
  localparam logic [7:0] USM_RST_FORMAT = 8'h00;
  localparam logic [7:0] USM_RST_BAUD   = 8'h00;
  localparam logic [1:0] USM_MODE_SPI   = 2'h3; // master_spi_mode
  localparam logic [1:0] USM_RESP_OKAY  = 2'h0;
  localparam logic [1:0] USM_RESP_SLVERR = 2'h2;
  localparam int         USM_FRAME_BITS = 8;
  localparam logic [4:0] USM_LAST_HALF  = 5'(2 * USM_FRAME_BITS - 1);

  // Link engine states
  typedef enum logic [1:0] {
    USM_L_IDLE  = 2'h1,
    USM_L_SHIFT = 2'h2
  } usm_link_state_t;

endpackage
`default_nettype wire

// *** verilog/usm_spi_master.sv ***
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`default_nettype none

// Notes on behaviour
// [RULE1] Receive flag high while unread byte held
// [RULE2] Transmit-complete after frame, no pending byte
// [RULE3] Buffer-empty flag shows one after reset
// [RULE4] Software writes zero to reserved bits
// [RULE5] Interrupt needs enable, global flag, status flag
// [RULE6] Receiver enable owns input; clear flushes
// [RULE7] No transfer without transmitter enabled
// [RULE8] Transmitter disable waits for empty path
// [RULE9] Mode bits 11 select master SPI
// [RULE10] Format bits accepted with mode write
// [RULE11] Bit order: one sends LSB first
// [RULE12] Phase picks leading or trailing sampling
// [RULE13] Polarity sets serial clock idle level
// [RULE14] Drives out, clock; reads in; no select
// [RULE15] Edge table per polarity and phase
// [RULE16] Each data write starts one exchange; a write taken in the ack_edge cycle leaves tx_busy set and never starts
// [RULE17] Error flags always read as zero
// [RULE18] Eight bits per frame, line idles high
// [RULE19] Full receive buffer drops the new byte
module usm_spi_master (
  // System clock and reset
  input  wire  logic                 aclk,
  input  wire  logic                 aresetn,
  // AXI4-Lite write address
  input  wire  logic [7:0]           s_axi_awaddr,
  input  wire  logic                 s_axi_awvalid,
  output logic                       s_axi_awready,
  // AXI4-Lite write data
  input  wire  logic [31:0]          s_axi_wdata,
  input  wire  logic [3:0]           s_axi_wstrb,
  input  wire  logic                 s_axi_wvalid,
  output logic                       s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire  logic                 s_axi_bready,
  // AXI4-Lite read address
  input  wire  logic [7:0]           s_axi_araddr,
  input  wire  logic                 s_axi_arvalid,
  output logic                       s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire  logic                 s_axi_rready,
  // Processor interrupt side
  input  wire  logic                 cpu_status_global_irq,
  input  wire  logic                 tx_done_irq_ack,
  output logic                       rx_done_irq,
  output logic                       tx_done_irq,
  output logic                       buf_empty_irq,
  // Serial link, own clock domain; the two ownership outputs are registered on aclk
  input  wire  logic                 link_clk,
  input  wire  logic                 serial_in_pin,
  output logic                       serial_out_pin,
  output logic                       serial_clock_pin,
  output logic                       serial_out_own,
  output logic                       serial_in_own
);
  import usm_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Bit position of frame bit idx for the chosen order
  function automatic logic [2:0] usm_pos(input logic [2:0] idx,
                                         input logic       lsb_first);
    usm_pos = lsb_first ? idx : 3'(7 - idx); // [RULE11]
  endfunction

  function automatic logic usm_mapped(input logic [7:0] a);
    usm_mapped = (a == USM_OFF_DATA)   || (a == USM_OFF_STATUS) ||
                 (a == USM_OFF_ENABLE) || (a == USM_OFF_FORMAT) ||
                 (a == USM_OFF_BAUD);
  endfunction

  // ----------------------------------------------------------------------
  // Core-domain state
  // ----------------------------------------------------------------------
  logic [7:0] enable_reg;  // serial_enable_control
  logic [7:0] format_reg;  // serial_format_control
  logic [7:0] baud_reg;    // baud_divider
  logic [7:0] tx_buf;      // Transmit buffer
  logic       tx_full;     // Transmit buffer holds a byte
  logic       tx_busy;     // Frame handed to link, not yet done
  logic       txc;         // transmit_complete_flag
  logic [7:0] rx_buf;      // Receive buffer
  logic       rx_full;     // receive_complete_flag
  logic       req_tgl;     // Start toggle to link
  logic [7:0] snap_data;   // Held stable for the link while busy
  logic [7:0] snap_fmt;
  logic [7:0] snap_baud;
  logic       ak_s1;       // Done toggle synchroniser
  logic       ak_s2;
  logic       ak_s3;
  logic       ack_edge;
  logic       ak_tgl;      // Done toggle from the link domain
  // Bus bookkeeping
  logic       aw_held;
  logic       w_held;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic       wr_lane0;
  logic       wr_go;
  logic       rd_go;
  logic       mode_spi;
  logic       launch;
  logic       data_wr;
  logic       data_rd;
  logic [7:0] link_rx;     // Link-side received byte, stable after done

  assign mode_spi = (format_reg[USM_B_MODEHI:USM_B_MODELO]
                     == USM_MODE_SPI);                       // [RULE9]
  assign wr_go    = aw_held && w_held && !s_axi_bvalid;
  assign rd_go    = s_axi_arvalid && !s_axi_rvalid;
  assign data_wr  = wr_go && wr_lane0 && (wr_addr == USM_OFF_DATA);
  assign data_rd  = rd_go && (s_axi_araddr == USM_OFF_DATA);
  assign ack_edge = ak_s2 ^ ak_s3;
  // Next frame leaves as soon as the link is free, unless its data write landed with ack_edge
  assign launch   = tx_full && !tx_busy && mode_spi;

  // ----------------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------------
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;

  // Address and data taken in either order, held until the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      wr_addr  <= 8'h00;
      wr_data  <= 8'h00;
      wr_lane0 <= 1'b0;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held   <= 1'b1;
        wr_data  <= s_axi_wdata[7:0];
        wr_lane0 <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // Response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= USM_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= usm_mapped(wr_addr) ? USM_RESP_OKAY : USM_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control registers; lane 0 carries all eight bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_reg <= USM_RST_ENABLE;
      format_reg <= USM_RST_FORMAT;
      baud_reg   <= USM_RST_BAUD;
    end else if (wr_go && wr_lane0) begin
      // Reserved bits are stored as written; software keeps them zero
      if (wr_addr == USM_OFF_ENABLE) begin
        enable_reg <= wr_data;                               // [RULE4]
      end
      // Mode and format land together in one write
      if (wr_addr == USM_OFF_FORMAT) begin
        format_reg <= wr_data;                               // [RULE10]
      end
      if (wr_addr == USM_OFF_BAUD) begin
        baud_reg <= wr_data;
      end
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  // Read data registered; error flags read zero in this mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= USM_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= usm_mapped(s_axi_araddr) ? USM_RESP_OKAY
                                                : USM_RESP_SLVERR;
      case (s_axi_araddr)
        USM_OFF_DATA:   s_axi_rdata <= {24'h00_0000, rx_buf};
        USM_OFF_STATUS: s_axi_rdata <= {24'h00_0000, rx_full, txc,
                                        !tx_full, 5'h00};    // [RULE17]
        USM_OFF_ENABLE: s_axi_rdata <= {24'h00_0000, enable_reg};
        USM_OFF_FORMAT: s_axi_rdata <= {24'h00_0000, format_reg};
        USM_OFF_BAUD:   s_axi_rdata <= {24'h00_0000, baud_reg};
        default:        s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Transmit path, core side
  // ----------------------------------------------------------------------
  // Data write fills the buffer only when the transmitter can send
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_full   <= 1'b0;                                     // [RULE3]
      tx_buf    <= 8'h00;
      tx_busy   <= 1'b0;
      req_tgl   <= 1'b0;
      snap_data <= 8'h00;
      snap_fmt  <= 8'h00;
      snap_baud <= 8'h00;
    end else begin
      // Refused while full, disabled or out of SPI mode
      if (data_wr && !tx_full && enable_reg[USM_B_TXEN] && mode_spi) begin
        tx_full <= 1'b1;                                     // [RULE16]
        tx_buf  <= wr_data;
      end else if (launch) begin
        tx_full   <= 1'b0;
        tx_busy   <= 1'b1;
        req_tgl   <= !req_tgl;                               // [RULE16]
        snap_data <= tx_buf;
        snap_fmt  <= format_reg;
        snap_baud <= baud_reg;
      end else if (ack_edge) begin
        tx_busy <= 1'b0;
      end
    end
  end

  // Transmit-complete; set wins over software or service clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txc <= 1'b0;
    end else if (ack_edge && !tx_full) begin
      txc <= 1'b1;                                           // [RULE2]
    end else if (tx_done_irq_ack ||
                 (wr_go && wr_lane0 && wr_addr == USM_OFF_STATUS &&
                  wr_data[USM_B_TXC])) begin
      txc <= 1'b0;                                           // [RULE2]
    end
  end

  // Pin ownership; transmitter release deferred until path is empty
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_out_own <= 1'b0;
      serial_in_own  <= 1'b0;
    end else begin
      serial_out_own <= enable_reg[USM_B_TXEN] || tx_full || tx_busy; // [RULE8]
      serial_in_own  <= enable_reg[USM_B_RXEN];              // [RULE6]
    end
  end

  // ----------------------------------------------------------------------
  // Receive path, core side
  // ----------------------------------------------------------------------
  // Done toggle crosses in; third stage only for edge detect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ak_s1 <= 1'b0;
      ak_s2 <= 1'b0;
      ak_s3 <= 1'b0;
    end else begin
      ak_s1 <= ak_tgl;
      ak_s2 <= ak_s1;
      ak_s3 <= ak_s2;
    end
  end

  // One-deep buffer; a full buffer keeps the older byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_full <= 1'b0;
      rx_buf  <= 8'h00;
    end else if (!enable_reg[USM_B_RXEN]) begin
      rx_full <= 1'b0;                                       // [RULE6]
    end else if (ack_edge && (!rx_full || data_rd)) begin
      rx_full <= 1'b1;                                       // [RULE1]
      rx_buf  <= link_rx;
    end else if (data_rd) begin
      rx_full <= 1'b0;                                       // [RULE1]
    end
  end

  // Each source needs enable, global flag and its own flag
  assign rx_done_irq   = enable_reg[USM_B_RXCIE] && cpu_status_global_irq
                         && rx_full;                         // [RULE5]
  assign tx_done_irq   = enable_reg[USM_B_TXCIE] && cpu_status_global_irq
                         && txc;                             // [RULE5]
  assign buf_empty_irq = enable_reg[USM_B_BUFFER_EMPTY_IRQ_ENABLE] && cpu_status_global_irq
                         && !tx_full;                        // [RULE5]

  // ----------------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------------
  logic            lr_s1;     // Reset release into link domain
  logic            link_rstn;
  logic            rq_s1;     // Start toggle synchroniser
  logic            rq_s2;
  logic            rq_s3;
  logic            in_s1;     // Serial input synchroniser
  logic            in_s2;
  usm_link_state_t lstate;
  logic [7:0]      div_cnt;   // Half-period divider
  logic [4:0]      half;      // Half-period index in frame
  logic [2:0]      bidx;      // Frame bit index
  logic            sck_lvl;   // Clock before polarity
  logic [7:0]      rx_sh;
  logic [7:0]      next_rx;
  logic            tick;
  logic            start;
  logic            lsb;
  logic            cpha;
  logic            samp;

  assign start = rq_s2 ^ rq_s3;
  assign tick  = (lstate == USM_L_SHIFT) && (div_cnt == snap_baud);
  assign lsb   = snap_fmt[USM_B_ORDER];
  assign cpha  = snap_fmt[USM_B_CPHA];
  // Even half ends on the leading edge; phase picks the sample edge
  assign samp  = tick && (half[0] == cpha);                  // [RULE12]

  // Reset and toggle synchronisers
  always_ff @(posedge link_clk) begin
    lr_s1     <= aresetn;
    link_rstn <= lr_s1;
    rq_s1     <= req_tgl;
    rq_s2     <= rq_s1;
    rq_s3     <= rq_s2;
    in_s1     <= serial_in_pin;
    in_s2     <= in_s1;
  end

  // Sampled bit merged into the receive shifter
  always_comb begin
    next_rx = rx_sh;
    if (samp) begin
      next_rx[usm_pos(bidx, lsb)] = in_s2;                   // [RULE14]
    end
  end

  // Frame engine: sixteen half periods per eight-bit frame
  always_ff @(posedge link_clk) begin
    if (!link_rstn) begin
      lstate         <= USM_L_IDLE;
      div_cnt        <= 8'h00;
      half           <= 5'h00;
      bidx           <= 3'h0;
      sck_lvl        <= 1'b0;
      rx_sh          <= 8'h00;
      link_rx        <= 8'h00;
      ak_tgl         <= 1'b0;
      serial_out_pin <= 1'b1;
    end else begin
      case (lstate)
        USM_L_IDLE: begin
          // Rest high only once the closing clock edge is on the pin,
          // so the last bit never moves together with its sample edge
          if (serial_clock_pin == snap_fmt[USM_B_CPOL]) begin
            serial_out_pin <= 1'b1;                          // [RULE18]
          end
          sck_lvl        <= 1'b0;
          if (start) begin
            lstate  <= USM_L_SHIFT;
            div_cnt <= 8'h00;
            half    <= 5'h00;
            bidx    <= 3'h0;
            // Phase zero presents the first bit before any edge
            if (!snap_fmt[USM_B_CPHA]) begin
              serial_out_pin <= snap_data[usm_pos(3'h0,
                                 snap_fmt[USM_B_ORDER])];    // [RULE15]
            end
          end
        end
        USM_L_SHIFT: begin
          div_cnt <= tick ? 8'h00 : 8'(div_cnt + 8'h01);
          rx_sh   <= next_rx;
          if (tick) begin
            sck_lvl <= !sck_lvl;
            half    <= 5'(half + 5'h01);
            // Setup on the edge that does not sample
            if (cpha && !half[0]) begin
              serial_out_pin <= snap_data[usm_pos(bidx, lsb)]; // [RULE15]
            end
            if (!cpha && half[0] && half != USM_LAST_HALF) begin
              serial_out_pin <= snap_data[usm_pos(3'(bidx + 3'h1), lsb)];
            end
            if (half[0]) begin
              bidx <= 3'(bidx + 3'h1);
            end
            if (half == USM_LAST_HALF) begin
              lstate  <= USM_L_IDLE;                         // [RULE18]
              link_rx <= next_rx;
              ak_tgl  <= !ak_tgl;
            end
          end
        end
        default: lstate <= USM_L_IDLE;
      endcase
    end
  end

  // Polarity inverts the whole clock, idle level included
  always_ff @(posedge link_clk) begin
    if (!link_rstn) begin
      serial_clock_pin <= 1'b0;
    end else begin
      serial_clock_pin <= (lstate == USM_L_SHIFT) ? (sck_lvl ^
                          snap_fmt[USM_B_CPOL]) : format_reg[USM_B_CPOL]; // [RULE13]
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_rx_flush_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !enable_reg[USM_B_RXEN] |=> !rx_full)                    // [RULE6]
    else $error("receive buffer not flushed");
  a_txc_cause: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(txc) |-> $past(ack_edge) && !$past(tx_full))       // [RULE2]
    else $error("transmit complete without finished frame");
  a_udre_reset: assert property (@(posedge aclk)
    !aresetn |=> !tx_full)                                   // [RULE3]
    else $error("buffer not empty after reset");
  a_irq_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    (rx_done_irq || tx_done_irq || buf_empty_irq) |-> cpu_status_global_irq)
    else $error("interrupt without global flag");            // [RULE5]
  a_no_tx_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    (!enable_reg[USM_B_TXEN] && !tx_full && !tx_busy)
    |=> !tx_full)                                            // [RULE7]
    else $error("byte accepted with transmitter off");
  a_tx_release: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(serial_out_own) |-> !$past(tx_full) && !$past(tx_busy))
    else $error("pin released with data pending");           // [RULE8]
  a_mode_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    (data_wr && !mode_spi && !tx_full) |=> !tx_full)         // [RULE9]
    else $error("data taken outside SPI mode");
  a_err_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_go && s_axi_araddr == USM_OFF_STATUS)
    |=> s_axi_rdata[4:0] == 5'h00)                           // [RULE17]
    else $error("error flags not zero");
  a_keep_old: assert property (@(posedge aclk) disable iff (!aresetn)
    (rx_full && ack_edge && !data_rd && enable_reg[USM_B_RXEN])
    |=> rx_buf == $past(rx_buf))                             // [RULE19]
    else $error("older byte overwritten");
  a_frame_bits: assert property (@(posedge link_clk) disable iff (!link_rstn)
    (tick && half == USM_LAST_HALF) |-> bidx == 3'h7)        // [RULE18]
    else $error("frame not eight bits");
  c_frame_done: cover property (@(posedge aclk) disable iff (!aresetn)
    ack_edge && rx_full);
  c_overflow: cover property (@(posedge aclk) disable iff (!aresetn)
    ack_edge && rx_full && !data_rd);
  c_txc_set: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(txc));
  c_lsb_mode3: cover property (@(posedge link_clk) disable iff (!link_rstn)
    start && lsb && cpha && snap_fmt[USM_B_CPOL]);

endmodule

`default_nettype wire

// *** tb/usm_spi_slave.sv ***
`default_nettype none
// ------------------------------------------------------------
// Behavioural slave on the far end of the serial link
// ------------------------------------------------------------
module usm_spi_slave (
  // Serial lines
  input  wire logic       sck,
  input  wire logic       mosi,
  output var  logic       miso,
  // Format and reply byte
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       lsb,
  input  wire logic [7:0] reply,
  output var  logic [7:0] got
);
  timeunit 1ns;
  timeprecision 1ps;
  int         k    = 0;    // Bits taken in this frame
  logic       lead = 1'h0; // Leading edge seen, guards idle-level moves
  logic [7:0] sh;          // Bytes assembled here
  // Edge decoder; a lone trailing move is an idle change, not a bit
  always @(sck) begin
    if (sck != cpol || lead) begin
      lead = (sck != cpol);
      if (lead ^ cpha) begin
        sh[lsb ? k : 7 - k] = mosi;
        k = k + 1;
        if (k == 8) begin
          got = sh;
          k = 0;
          if (!cpha) miso = reply[lsb ? 0 : 7];
        end
      end else if (k > 0 || cpha) miso = reply[lsb ? k : 7 - k];
    end
  end
  // Phase zero needs the first bit before the first edge
  always @(reply, cpha, lsb) if (k == 0 && !cpha) miso = reply[lsb ? 0 : 7];
endmodule
`default_nettype wire

// *** tb/usm_spi_master_bench.sv ***
`default_nettype none
module usm_spi_master_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import usm_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic aclk = 1'h0, link_clk = 1'h0, aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, got, tx;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h1;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h1, tx_done_irq_ack = 1'h0;
  logic cpu_status_global_irq = 1'h0, serial_in_pin, s_axi_awready;
  logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic rx_done_irq, tx_done_irq, buf_empty_irq, serial_out_pin;
  logic serial_clock_pin, serial_out_own, serial_in_own;
  logic cpol = 1'h0, cpha = 1'h0, lsb = 1'h0, g;
  logic [7:0] reply = 8'h00;
  int seed = 32'h83204D3E, n_mismatch = 0, checks_done = 0, cyc = 0;
  usm_spi_master dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cpu_status_global_irq, .tx_done_irq_ack,
    .rx_done_irq, .tx_done_irq, .buf_empty_irq, .link_clk, .serial_in_pin,
    .serial_out_pin, .serial_clock_pin, .serial_out_own, .serial_in_own);
  usm_spi_slave peer (.sck(serial_clock_pin), .mosi(serial_out_pin),
    .miso(serial_in_pin), .cpol, .cpha, .lsb, .reply, .got);
  // Two unrelated clocks
  initial forever #10 aclk = ~aclk;
  initial begin
    #3;
    forever #7.5 link_clk = ~link_clk;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  // Write: both halves offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    chk("bresp", 32'(USM_RESP_OKAY), 32'(s_axi_bresp));
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk("read", e, d);
    chk("rresp", 32'(USM_RESP_OKAY), 32'(rr));
  endtask
  // Poll until every flag in the mask is up
  task automatic wt(input logic [7:0] m);
    do rd(USM_OFF_STATUS); while ((d[7:0] & m) != m);
  endtask
  task automatic end_sim();
    if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    rc(USM_OFF_STATUS, 32'h20);
    rd(8'h40);
    chk("slverr", 32'(USM_RESP_SLVERR), 32'(rr));
    wr(USM_OFF_ENABLE, 8'h18);
    wr(USM_OFF_DATA, 8'hA5);
    repeat (60) @(posedge aclk);
    rc(USM_OFF_STATUS, 32'h20);
    // Half period must outlast the input synchroniser
    wr(USM_OFF_BAUD, 8'h04);
    for (int m = 0; m < 4; m++) begin
      {cpol, cpha} = 2'(m);
      lsb = 1'($random(seed));
      tx = 8'($random(seed));
      reply = 8'($random(seed));
      g = 1'($random(seed));
      cpu_status_global_irq <= g;
      wr(USM_OFF_FORMAT, {USM_MODE_SPI, 3'h0, lsb, cpha, cpol});
      wr(USM_OFF_ENABLE, 8'hF8);
      wr(USM_OFF_DATA, tx);
      wt(8'hC0);
      chk("status", 32'hE0, d);
      chk("irqs", {29'h0, {3{g}}}, {29'h0, rx_done_irq, tx_done_irq,
        buf_empty_irq});
      chk("mosi", 32'(tx), 32'(got));
      chk("own", 32'h3, {30'h0, serial_out_own, serial_in_own});
      if (m == 3) wr(USM_OFF_ENABLE, 8'hE8);
      else rc(USM_OFF_DATA, 32'(reply));
      rc(USM_OFF_STATUS, 32'h60);
      if (m[0]) begin
        tx_done_irq_ack <= 1'h1;
        @(posedge aclk);
        tx_done_irq_ack <= 1'h0;
      end else wr(USM_OFF_STATUS, 8'h40);
      rc(USM_OFF_STATUS, 32'h20);
    end
    // Disable while a frame is still on the wire
    wr(USM_OFF_DATA, tx);
    wr(USM_OFF_ENABLE, 8'h00);
    chk("own busy", 32'h1, 32'(serial_out_own));
    wt(8'h40);
    repeat (4) @(posedge aclk);
    chk("own idle", 32'h0, 32'(serial_out_own));
    // Unread byte kept, the next one dropped
    wr(USM_OFF_ENABLE, 8'h18);
    wr(USM_OFF_DATA, tx);
    wt(8'hC0);
    wr(USM_OFF_STATUS, 8'h40);
    tx = reply;
    reply = ~reply;
    wr(USM_OFF_DATA, tx);
    wt(8'h40);
    rc(USM_OFF_DATA, 32'(tx));
    end_sim();
  end
endmodule
`default_nettype wire
